// ### mpi_defines.svh
// Purpose: constants of the mac/phy internal interface block
// Assumes: apb with 32-bit data, 50 mhz system clock
// Notes:   offsets are byte addresses
`ifndef MPI_DEFINES_SVH
`define MPI_DEFINES_SVH

`define MPI_OFF_CTRL       12'h000
`define MPI_OFF_STATUS     12'h008
`define MPI_OFF_MGMT       12'h020

`define MPI_CTRL_FD        0
`define MPI_CTRL_SLU       6
`define MPI_CTRL_SPD_LO    8
`define MPI_CTRL_FRCSPD    11
`define MPI_CTRL_PM_EN     21
`define MPI_CTRL_PWR_LO    22
`define MPI_PHY_RESET_CONTROL_BIT   31

`define MPI_STAT_FD        0
`define MPI_STAT_LU        1
`define MPI_STAT_LSC       2
`define MPI_STAT_SPD_LO    6
`define MPI_STAT_GMII      8

`define MPI_MGMT_REG_LO    16
`define MPI_MGMT_PHY_LO    21
`define MPI_MGMT_OP_LO     26
`define MPI_MGMT_READY     28

`define MPI_OP_WRITE       2'h1
`define MPI_OP_READ        2'h2
`define MPI_SPD_10         2'h0
`define MPI_SPD_100        2'h1
`define MPI_SPD_1000       2'h2

`define MPI_CTRL_RESET     32'h0000_0000
`define MPI_SYS_PERIOD_NS  20
`define MPI_MDC_HALF_NS    200
`define MPI_MDC_HALF_CYC   \
	((`MPI_MDC_HALF_NS + `MPI_SYS_PERIOD_NS - 1) / `MPI_SYS_PERIOD_NS)
`define MPI_MDIO_BITS      7'd64
`define MPI_MDIO_TA_BIT    7'd46

`endif

// ### mpi_pkg.sv
// Purpose: types of the mac/phy internal interface block
// Assumes: constants come from mpi_defines.svh
// Notes:   all state of the block is one packed struct
package mpi_pkg;
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} mpi_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} mpi_apb_rsp_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} mpi_byte_t;

	typedef enum logic [1:0] {
		MPI_MD_IDLE  = 2'b01,
		MPI_MD_SHIFT = 2'b10
	} mpi_md_state_t;

	typedef struct packed {
		mpi_md_state_t md_st;
		logic        phy_rst, slu, frcspd, ffd, pm_en;
		logic [1:0]  fspd, pwr;
		logic        lsc, link_s1, link_s2, link_p;
		logic        dup_s1, dup_s2;
		logic [1:0]  spd_s1, spd_s2, cur_spd;
		logic        cur_fd;
		logic        mdc;
		logic [7:0]  div;
		logic [6:0]  bitn;
		logic [31:0] frame;
		logic        rd, ready, mdio_o, mdio_oe, mi_s1, mi_s2;
		logic [15:0] rdata;
		logic [4:0]  mreg, mphy;
		logic        tck_s1, tck_s2, tck_p, tx_en, hi, have;
		logic [7:0]  txd, hold;
		logic        rck_s1, rck_s2, rck_p, dv_s1, dv_s2;
		logic [7:0]  rxd_s1, rxd_s2;
		logic        nib, in_frame, rx_end;
		logic [3:0]  lo;
		mpi_byte_t   rx;
		logic [31:0] prdata;
		logic        pslverr;
	} mpi_state_t;
endpackage

// ### mpi_mac_phy.sv
// Purpose: mac side of the internal mac/phy link: gmii/mii data path,
//          management channel master, reset, link/speed/duplex sideband
// Assumes: phy clocks and sideband arrive asynchronously and are sampled
// Notes:   apb answers with zero wait states
// Contract
// - Data moves as bytes at 1000 Mb/s and as nibble pairs at 10/100.
// - Half duplex is allowed at 10/100 only, 1000 is always full.
// - Mac speed and duplex follow the phy or the software setting.
// - A serial data and clock management channel is run from a register.
// - Management access works the same in both data path modes.
// - The phy reset combines the host reset and a software bit.
// - Link up shows the phy link while slu is set, changes are flagged, speed re-sensed.
// - The phy duplex is taken at link restore and shown when not forced.
// - The phy speed is taken and shown when mac speed is not forced.
// - The mac power state goes to the phy ungated, with a separate pm enable.
// - Transmit and receive run at once, each framed on its own.
// - Transmit enable is high exactly while transmit data is valid.
`timescale 1ns/100ps
`include "mpi_defines.svh"

module mpi_mac_phy (
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire mpi_pkg::mpi_apb_req_t apb_req,
	output logic                       apb_pready,
	output logic                       apb_pslverr,
	output logic [31:0]                apb_prdata,
	input  wire logic                  tx_valid,
	input  wire logic [7:0]            tx_data,
	output logic                       tx_ready,
	output mpi_pkg::mpi_byte_t         rx_out,
	output logic                       rx_end,
	input  wire logic                  phy_tx_clk,
	output logic                       phy_tx_en,
	output logic [7:0]                 phy_txd,
	input  wire logic                  phy_rx_clk,
	input  wire logic                  phy_rx_dv,
	input  wire logic [7:0]            phy_rxd,
	output logic                       phy_mdc,
	input  wire logic                  phy_mdio_i,
	output logic                       phy_mdio_o,
	output logic                       phy_mdio_oe,
	output logic                       phy_reset,
	input  wire logic                  phy_link,
	input  wire logic                  phy_duplex_ind,
	input  wire logic [1:0]            phy_speed_ind,
	output logic [1:0]                 power_state_ind,
	output logic                       phy_pm_en
);
	import mpi_pkg::*;

	mpi_state_t q;
	mpi_state_t d;
	logic       wr;
	logic       rd_setup;
	logic       hit;
	logic       tck_rise;
	logic       rck_rise;
	logic       gmii;
	logic [31:0] ctrl_v;
	logic [31:0] stat_v;
	logic [31:0] mgmt_v;

	always_comb
	begin
		d = q;
		d.rx.valid = 1'b0;
		d.rx_end = 1'b0;
		gmii = (q.cur_spd == `MPI_SPD_1000);
		tck_rise = q.tck_s2 & ~q.tck_p;
		rck_rise = q.rck_s2 & ~q.rck_p;

		// two-stage sampling of everything the phy drives
		d.link_s1 = phy_link;
		d.link_s2 = q.link_s1;
		d.link_p = q.link_s2;
		d.dup_s1 = phy_duplex_ind;
		d.dup_s2 = q.dup_s1;
		d.spd_s1 = phy_speed_ind;
		d.spd_s2 = q.spd_s1;
		d.mi_s1 = phy_mdio_i;
		d.mi_s2 = q.mi_s1;
		d.tck_s1 = phy_tx_clk;
		d.tck_s2 = q.tck_s1;
		d.tck_p = q.tck_s2;
		d.rck_s1 = phy_rx_clk;
		d.rck_s2 = q.rck_s1;
		d.rck_p = q.rck_s2;
		d.dv_s1 = phy_rx_dv;
		d.dv_s2 = q.dv_s1;
		d.rxd_s1 = phy_rxd;
		d.rxd_s2 = q.rxd_s1;

		// speed/duplex resolution, re-sensed on every link change
		if (q.frcspd)
		begin
			d.cur_spd = q.fspd;
			d.cur_fd = q.ffd | (q.fspd == `MPI_SPD_1000);
		end
		else if (q.link_s2 != q.link_p)
		begin
			d.cur_spd = q.spd_s2;
			d.cur_fd = q.dup_s2 | (q.spd_s2 == `MPI_SPD_1000);
		end
		if (q.link_s2 != q.link_p)
			d.lsc = 1'b1;

		ctrl_v = '0;
		ctrl_v[`MPI_CTRL_FD] = q.ffd;
		ctrl_v[`MPI_CTRL_SLU] = q.slu;
		ctrl_v[`MPI_CTRL_SPD_LO +: 2] = q.fspd;
		ctrl_v[`MPI_CTRL_FRCSPD] = q.frcspd;
		ctrl_v[`MPI_CTRL_PM_EN] = q.pm_en;
		ctrl_v[`MPI_CTRL_PWR_LO +: 2] = q.pwr;
		ctrl_v[`MPI_PHY_RESET_CONTROL_BIT] = q.phy_rst;
		stat_v = '0;
		stat_v[`MPI_STAT_FD] = q.cur_fd;
		stat_v[`MPI_STAT_LU] = q.link_s2 & q.slu;
		stat_v[`MPI_STAT_LSC] = q.lsc;
		stat_v[`MPI_STAT_SPD_LO +: 2] = q.cur_spd;
		stat_v[`MPI_STAT_GMII] = gmii;
		mgmt_v = '0;
		mgmt_v[15:0] = q.rdata;
		mgmt_v[`MPI_MGMT_REG_LO +: 5] = q.mreg;
		mgmt_v[`MPI_MGMT_PHY_LO +: 5] = q.mphy;
		mgmt_v[`MPI_MGMT_OP_LO +: 2] = q.rd ? `MPI_OP_READ : `MPI_OP_WRITE;
		mgmt_v[`MPI_MGMT_READY] = q.ready;

		// apb: read data captured in setup, everything lands in access
		hit = (apb_req.paddr == `MPI_OFF_CTRL) |
			(apb_req.paddr == `MPI_OFF_STATUS) |
			(apb_req.paddr == `MPI_OFF_MGMT);
		rd_setup = apb_req.psel & ~apb_req.penable;
		wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
		if (rd_setup)
		begin
			d.pslverr = ~hit;
			unique case (apb_req.paddr)
				`MPI_OFF_CTRL:   d.prdata = ctrl_v;
				`MPI_OFF_STATUS: d.prdata = stat_v;
				`MPI_OFF_MGMT:   d.prdata = mgmt_v;
				default:         d.prdata = 32'h0000_0000;
			endcase
		end
		if (wr && apb_req.paddr == `MPI_OFF_CTRL)
		begin
			d.ffd = apb_req.pwdata[`MPI_CTRL_FD];
			d.slu = apb_req.pwdata[`MPI_CTRL_SLU];
			d.fspd = apb_req.pwdata[`MPI_CTRL_SPD_LO +: 2];
			d.frcspd = apb_req.pwdata[`MPI_CTRL_FRCSPD];
			d.pm_en = apb_req.pwdata[`MPI_CTRL_PM_EN];
			d.pwr = apb_req.pwdata[`MPI_CTRL_PWR_LO +: 2];
			d.phy_rst = apb_req.pwdata[`MPI_PHY_RESET_CONTROL_BIT];
		end
		// write one to clear; a link change in the same cycle still wins
		if (wr && apb_req.paddr == `MPI_OFF_STATUS &&
			apb_req.pwdata[`MPI_STAT_LSC] && q.link_s2 == q.link_p)
			d.lsc = 1'b0;

		// management channel: 32 preamble ones then the 32-bit frame
		unique case (q.md_st)
			MPI_MD_IDLE:
			begin
				d.mdio_oe = 1'b0;
				// writes while busy are dropped; the frame is the same
				// whatever mode the data path is in
				if (wr && apb_req.paddr == `MPI_OFF_MGMT)
				begin
					d.rd = apb_req.pwdata[`MPI_MGMT_OP_LO +: 2] == `MPI_OP_READ;
					d.mreg = apb_req.pwdata[`MPI_MGMT_REG_LO +: 5];
					d.mphy = apb_req.pwdata[`MPI_MGMT_PHY_LO +: 5];
					d.frame = {2'b01,
						apb_req.pwdata[`MPI_MGMT_OP_LO +: 2],
						apb_req.pwdata[`MPI_MGMT_PHY_LO +: 5],
						apb_req.pwdata[`MPI_MGMT_REG_LO +: 5],
						2'b10, apb_req.pwdata[15:0]};
					d.ready = 1'b0;
					d.bitn = 7'd0;
					d.div = 8'h00;
					d.mdc = 1'b0;
					d.mdio_o = 1'b1;
					d.mdio_oe = 1'b1;
					d.md_st = MPI_MD_SHIFT;
				end
			end
			MPI_MD_SHIFT:
			begin
				if (q.div == 8'(`MPI_MDC_HALF_CYC - 1))
				begin
					d.div = 8'h00;
					d.mdc = ~q.mdc;
					if (!q.mdc)
					begin
						// rising mdc: phy has had a half period to settle
						if (q.rd && q.bitn >= 7'd48)
							d.rdata = {q.rdata[14:0], q.mi_s2};
					end
					else if (q.bitn == `MPI_MDIO_BITS - 7'd1)
					begin
						d.mdio_oe = 1'b0;
						d.ready = 1'b1;
						d.md_st = MPI_MD_IDLE;
					end
					else
					begin
						// falling mdc: present the next bit
						d.bitn = q.bitn + 7'd1;
						if (q.bitn >= 7'd31)
						begin
							d.mdio_o = q.frame[31];
							d.frame = {q.frame[30:0], 1'b0};
						end
						if (q.rd && q.bitn == `MPI_MDIO_TA_BIT - 7'd1)
							d.mdio_oe = 1'b0;
					end
				end
				else
					d.div = q.div + 8'h01;
			end
			default: d.md_st = MPI_MD_IDLE;
		endcase

		// transmit: one byte held, sent whole or as low then high nibble
		if (tx_valid && !q.have)
		begin
			d.hold = tx_data;
			d.have = 1'b1;
		end
		if (tck_rise)
		begin
			if (q.have)
			begin
				d.tx_en = 1'b1;
				if (gmii)
				begin
					d.txd = q.hold;
					d.have = 1'b0;
				end
				else
				begin
					d.txd = q.hi ? {4'h0, q.hold[7:4]} : {4'h0, q.hold[3:0]};
					d.hi = ~q.hi;
					d.have = ~q.hi;
				end
			end
			else
			begin
				d.tx_en = 1'b0;
				d.txd = 8'h00;
				d.hi = 1'b0;
			end
		end

		// receive: framed only by the sampled receive valid
		if (rck_rise)
		begin
			d.in_frame = q.dv_s2;
			if (q.dv_s2)
			begin
				if (gmii)
				begin
					d.rx.valid = 1'b1;
					d.rx.data = q.rxd_s2;
				end
				else if (q.nib)
				begin
					d.rx.valid = 1'b1;
					d.rx.data = {q.rxd_s2[3:0], q.lo};
					d.nib = 1'b0;
				end
				else
				begin
					d.lo = q.rxd_s2[3:0];
					d.nib = 1'b1;
				end
			end
			else
			begin
				// an odd trailing nibble is dropped
				d.nib = 1'b0;
				d.rx_end = q.in_frame;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			q <= '0;
			q.md_st <= MPI_MD_IDLE;
			q.ready <= 1'b1;
			q.cur_fd <= 1'b1;
		end
		else
			q <= d;
	end

	assign apb_pready = apb_req.psel & apb_req.penable;
	assign apb_pslverr = apb_pready & q.pslverr;
	assign apb_prdata = q.prdata;
	assign tx_ready = ~q.have;
	assign rx_out = q.rx;
	assign rx_end = q.rx_end;
	assign phy_tx_en = q.tx_en;
	assign phy_txd = q.txd;
	assign phy_mdc = q.mdc;
	assign phy_mdio_o = q.mdio_o;
	assign phy_mdio_oe = q.mdio_oe;
	// asserted at once on either source; no flop on the host reset path
	assign phy_reset = rst | q.phy_rst;
	assign power_state_ind = q.pwr;
	assign phy_pm_en = q.pm_en;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence link_edge;
		q.link_s2 != q.link_p;
	endsequence
	sequence auto_speed;
		!q.frcspd;
	endsequence

	phy_reset_mix_a: assert property (q.phy_rst |-> phy_reset)
		else $error("phy reset not driven by software bit");
	phy_reset_rel_a: assert property ($fell(phy_reset) |-> !q.phy_rst)
		else $error("phy reset released while a source active");
	half_1000_a: assert property (gmii |-> q.cur_fd)
		else $error("half duplex at 1000");
	lsc_set_a: assert property (link_edge |=> q.lsc)
		else $error("link change not flagged");
	speed_take_a: assert property (auto_speed and link_edge |=>
		q.cur_spd == $past(q.spd_s2))
		else $error("phy speed not taken on link change");
	duplex_take_a: assert property (auto_speed and link_edge and
		q.spd_s2 != `MPI_SPD_1000 |=> q.cur_fd == $past(q.dup_s2))
		else $error("phy duplex not taken on link change");
	tx_en_data_a: assert property (tck_rise && q.have |=> phy_tx_en)
		else $error("transmit enable missing with data");
	tx_en_off_a: assert property (tck_rise && !q.have |=>
		!phy_tx_en && phy_txd == 8'h00)
		else $error("transmit enable without data");
	rx_gmii_a: assert property (rck_rise && q.dv_s2 && gmii |=>
		rx_out.valid && rx_out.data == $past(q.rxd_s2))
		else $error("gmii byte lost");
	mdio_start_a: assert property (
		q.md_st == MPI_MD_IDLE && wr && apb_req.paddr == `MPI_OFF_MGMT
		|=> !q.ready && phy_mdio_oe ##1 phy_mdio_o [*8])
		else $error("management frame did not start with preamble");
endmodule // mpi_mac_phy

// ### mpi_phy_model.sv
// Purpose: behavioural phy on the far side of the mac/phy link
// Assumes: link clocks run free at 160 ns, mdio line has a pull-up
// Notes:   one 64-bit management frame, 32 word register file
`timescale 1ns/100ps
`include "mpi_defines.svh"

module mpi_phy_model (
	output logic       tx_clk,
	output logic       rx_clk,
	input  wire logic  tx_en,
	input  wire logic [7:0] txd,
	output logic       rx_dv,
	output logic [7:0] rxd,
	input  wire logic  mdc,
	input  wire logic  mdio,
	output logic       md_out,
	output logic       md_drive,
	output logic       link,
	output logic       dup,
	output logic [1:0] spd
);
	logic [7:0]  txq[$];
	logic [15:0] mem[32];
	logic [63:0] sr;
	logic [4:0]  ra;
	logic [3:0]  lo;
	logic        rd;
	logic        hi;
	int          n;
	wire         gm = (spd == 2'h2);

	initial
	begin
		{tx_clk, rx_clk, rx_dv, rxd, md_out, md_drive} = '0;
		{link, dup, spd, rd, hi, n} = '0;
		#37;
		forever #80 tx_clk = ~tx_clk;
	end

	always #80 rx_clk = ~rx_clk;

	task automatic set_link(input logic l, input logic d,
		input logic [1:0] sp);
		dup = d;
		spd = sp;
		link = l;
	endtask

	// mii bytes arrive low nibble first and pair on the second edge
	always @(posedge tx_clk)
		if (tx_en !== 1'b1)
			hi = 1'b0;
		else if (gm)
			txq.push_back(txd);
		else if (!hi)
		begin
			lo = txd[3:0];
			hi = 1'b1;
		end
		else
		begin
			txq.push_back({txd[3:0], lo});
			hi = 1'b0;
		end

	task automatic rx_frame(input logic [7:0] b[$]);
		foreach (b[j])
			for (int h = 0; h < (gm ? 1 : 2); h++)
			begin
				@(negedge rx_clk);
				rx_dv = 1'b1;
				rxd = gm ? b[j] : {4'h0, h ? b[j][7:4] : b[j][3:0]};
			end
		@(negedge rx_clk);
		rx_dv = 1'b0;
		rxd = ~rxd;
	endtask

	always @(posedge mdc)
	begin
		sr = {sr[62:0], mdio};
		n++;
		if (n == 36)
			rd = (sr[1:0] == `MPI_OP_READ);
		if (n == 46)
			ra = sr[4:0];
		if (n == 64)
		begin
			if (!rd)
				mem[ra] = sr[15:0];
			n = 0;
			rd = 1'b0;
			md_drive = 1'b0;
		end
	end

	always @(negedge mdc)
		if (rd && n >= 47)
		begin
			md_drive = 1'b1;
			md_out = (n == 47) ? 1'b0 : mem[ra][63 - n];
		end
endmodule // mpi_phy_model

// ### mpi_testbench.sv
// Purpose: self-checking bench of the mac/phy internal link block
// Assumes: 50 mhz system clock, phy model on the far side
// Notes:   random bytes and values come from a fixed lfsr seed
`timescale 1ns/100ps
`include "mpi_defines.svh"
`define CHK(g, e) \
	n_compared++; \
	if ((g) !== (e)) \
	begin \
		err_total++; \
		$display("[ERR] %0t got %h want %h", $time, g, e); \
	end

module testbench;
	import mpi_pkg::*;
	logic         clk_sys = 1'b0;
	logic         rst = 1'b1;
	mpi_apb_req_t req = '0;
	logic         tx_valid = 1'b0;
	logic [7:0]   tx_data = 8'h00;
	logic         pready, pslverr, tx_ready, rx_end, slverr;
	logic [31:0]  prdata, rdata;
	mpi_byte_t    rx_out;
	wire          tx_clk, rx_clk, tx_en, rx_dv, mdc, mac_o, mac_oe;
	wire          phy_o, phy_oe, phy_reset, link, dup, pm_en;
	wire [7:0]    txd, rxd;
	wire [1:0]    spd, pwr;
	wire          mdio = mac_oe ? mac_o : (phy_oe ? phy_o : 1'b1);
	int           err_total = 0;
	int           n_compared = 0;
	int           n_end = 0;
	int           i, s, k, e0;
	logic [15:0]  rs = 16'd19836;
	logic [15:0]  w;
	logic [7:0]   q[$], rxq[$];

	always #10 clk_sys = ~clk_sys;

	mpi_mac_phy DUT (.clk_sys(clk_sys), .rst(rst), .apb_req(req),
		.apb_pready(pready), .apb_pslverr(pslverr), .apb_prdata(prdata),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.rx_out(rx_out), .rx_end(rx_end), .phy_tx_clk(tx_clk),
		.phy_tx_en(tx_en), .phy_txd(txd), .phy_rx_clk(rx_clk),
		.phy_rx_dv(rx_dv), .phy_rxd(rxd), .phy_mdc(mdc),
		.phy_mdio_i(mdio), .phy_mdio_o(mac_o), .phy_mdio_oe(mac_oe),
		.phy_reset(phy_reset), .phy_link(link), .phy_duplex_ind(dup),
		.phy_speed_ind(spd), .power_state_ind(pwr), .phy_pm_en(pm_en));

	mpi_phy_model PHY (.tx_clk(tx_clk), .rx_clk(rx_clk), .tx_en(tx_en),
		.txd(txd), .rx_dv(rx_dv), .rxd(rxd), .mdc(mdc), .mdio(mdio),
		.md_out(phy_o), .md_drive(phy_oe), .link(link), .dup(dup),
		.spd(spd));

	always @(posedge clk_sys)
	begin
		if (rx_out.valid === 1'b1)
			rxq.push_back(rx_out.data);
		if (rx_end === 1'b1)
			n_end++;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	function automatic logic [31:0] exp_stat(input logic l, input logic f,
		input logic [1:0] sp, input logic c);
		return {23'h0, sp == 2'h2, sp, 3'h0, c, l, f};
	endfunction

	task automatic summarize;
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic stall;
		err_total++;
		$display("[ERR] %0t wait ran out", $time);
		summarize();
	endtask

	// an idle edge first, so no strobe is assigned twice in one step
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int c;
		@(posedge clk_sys);
		req.psel <= 1'b1;
		req.pwrite <= wr;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge clk_sys);
		req.penable <= 1'b1;
		c = 0;
		do
		begin
			@(posedge clk_sys);
			c++;
		end
		while (pready !== 1'b1 && c < 50);
		if (c == 50)
			stall();
		rdata = prdata;
		slverr = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic poll(input logic [11:0] a, input int b, input logic v);
		int c;
		c = 0;
		do
		begin
			apb(1'b0, a, 32'h0);
			c++;
		end
		while (rdata[b] !== v && c < 1000);
		if (c == 1000)
			stall();
	endtask

	task automatic mgmt(input logic [1:0] op, input logic [4:0] ra,
		input logic [15:0] d);
		apb(1'b1, `MPI_OFF_MGMT, {4'h0, op, 5'h01, ra, d});
		poll(`MPI_OFF_MGMT, `MPI_MGMT_READY, 1'b1);
	endtask

	task automatic send(input logic [7:0] b[$]);
		int c;
		foreach (b[j])
		begin
			tx_valid <= 1'b1;
			tx_data <= b[j];
			c = 0;
			do
			begin
				@(posedge clk_sys);
				c++;
			end
			while (tx_ready !== 1'b1 && c < 200);
			if (c == 200)
				stall();
		end
		tx_valid <= 1'b0;
	endtask

	initial
	begin
		for (i = 0; i < 16; i++)
			@(posedge clk_sys);
		`CHK(phy_reset, 1'b1)
		rst <= 1'b0;
		apb(1'b0, `MPI_OFF_CTRL, 32'h0);
		`CHK(phy_reset, 1'b0)
		`CHK(rdata, `MPI_CTRL_RESET)
		apb(1'b0, 12'h010, 32'h0);
		`CHK({slverr, rdata}, {1'b1, 32'h0})
		apb(1'b1, `MPI_OFF_CTRL, 32'h8000_0000);
		@(posedge clk_sys);
		`CHK(phy_reset, 1'b1)
		for (i = 0; i < 2; i++)
		begin
			rs = lfsr(rs);
			apb(1'b1, `MPI_OFF_CTRL, {8'h0, rs[1:0], i[0], 21'h0});
			@(posedge clk_sys);
			@(posedge clk_sys);
			`CHK({pwr, pm_en, phy_reset}, {rs[1:0], i[0], 1'b0})
		end
		apb(1'b1, `MPI_OFF_CTRL, 32'h40);
		for (s = 0; s < 3; s++)
		begin
			rs = lfsr(rs);
			PHY.set_link(1'b0, rs[0] & (s != 2), s[1:0]);
			poll(`MPI_OFF_STATUS, `MPI_STAT_LU, 1'b0);
			PHY.set_link(1'b1, rs[0] & (s != 2), s[1:0]);
			poll(`MPI_OFF_STATUS, `MPI_STAT_LU, 1'b1);
			apb(1'b0, `MPI_OFF_STATUS, 32'h0);
			`CHK(rdata, exp_stat(1, (s == 2) | rs[0], s[1:0], 1))
			apb(1'b1, `MPI_OFF_STATUS, 32'h4);
			apb(1'b0, `MPI_OFF_STATUS, 32'h0);
			`CHK(rdata[2], 1'b0)
			w = lfsr(rs);
			mgmt(`MPI_OP_WRITE, rs[4:0], w);
			`CHK(PHY.mem[rs[4:0]], w)
			mgmt(`MPI_OP_READ, rs[4:0], 16'h0);
			`CHK(rdata[15:0], w)
			q = {};
			for (i = 0; i < 6; i++)
			begin
				rs = lfsr(rs);
				q.push_back(rs[7:0]);
			end
			PHY.txq = {};
			rxq = {};
			e0 = n_end;
			// both directions at once, each framed on its own
			fork
				send(q);
				PHY.rx_frame(q);
			join
			k = 0;
			while ((tx_en !== 1'b0 || n_end == e0) && k < 300)
			begin
				@(posedge clk_sys);
				k++;
			end
			if (k == 300)
				stall();
			`CHK(PHY.txq.size(), 6)
			`CHK(rxq.size(), 6)
			`CHK(n_end - e0, 1)
			foreach (q[j])
			begin
				`CHK(PHY.txq[j], q[j])
				`CHK(rxq[j], q[j])
			end
		end
		for (s = 0; s < 3; s++)
		begin
			rs = lfsr(rs);
			apb(1'b1, `MPI_OFF_CTRL,
				32'h840 | {22'h0, s[1:0], 7'h0, rs[0]});
			apb(1'b0, `MPI_OFF_STATUS, 32'h0);
			`CHK(rdata[8:6], {s == 2, s[1:0]})
			`CHK(rdata[0], (s == 2) | rs[0])
		end
		summarize();
	end
endmodule // testbench
